/* aaf_regs.svh */
// Register indexes, field positions, reset values and counts of the filter.
`ifndef AAF_REGS_SVH
`define AAF_REGS_SVH

`define AAF_IDX_W 10
`define AAF_IDX_CTRL 10'h110
`define AAF_IDX_RPT 10'h111
`define AAF_IDX_CNT 10'h112
`define AAF_IDX_ACCL 10'h113
`define AAF_IDX_ACCH 10'h114
`define AAF_IDX_STAT 10'h115
`define AAF_IDX_FLT 10'h116
`define AAF_IDX_UTH 10'h117
`define AAF_IDX_LTH 10'h118
`define AAF_IDX_SETP 10'h119

`define AAF_CTRL_MODE_LSB 0
`define AAF_CTRL_SHIFT_LSB 4
`define AAF_CTRL_CLEAR_BIT 8
`define AAF_CTRL_RCSEL_BIT 9
`define AAF_CTRL_GO_BIT 10

`define AAF_STAT_OV_BIT 7
`define AAF_STAT_UPPER_BIT 6
`define AAF_STAT_LOWER_BIT 5
`define AAF_STAT_COMPUTATION_STATUS_BIT_BIT 4
`define AAF_STAT_RESET 8'h00
`define AAF_STAGE_UNUSED 3'b100
`define AAF_STAGE_IDLE 3'b000

`define AAF_MD_BASIC 3'b000
`define AAF_MD_ACC 3'b001
`define AAF_MD_AVG 3'b010
`define AAF_MD_BAVG 3'b011
`define AAF_MD_LPF 3'b100

`define AAF_CLR_RC_CYCLES 3'd5
`define AAF_THR_RESET 16'h0000

`endif

/* aaf_pkg.sv */
// Types shared by the accumulate and filter unit.
package aaf_pkg;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } aaf_apb_req_s;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } aaf_apb_rsp_s;

  typedef struct packed {
    logic valid;
    logic [15:0] result;
    logic [2:0] stage;
  } aaf_core_s;

  typedef enum logic {CLR_IDLE, CLR_WAIT} aaf_clr_e;

endpackage

/* aaf_filter_calc.sv */
// Next accumulator and filtered value for each computation mode.
`timescale 1ns/1ps
`include "aaf_regs.svh"
module aaf_filter_calc #(
  parameter int ACC_W = 16
) (
  // Settings.
  input wire logic [2:0] mode,
  input wire logic [2:0] shift,
  // Operands.
  input wire logic [ACC_W-1:0] base,
  input wire logic [ACC_W-1:0] sample,
  // Results.
  output logic [ACC_W-1:0] acc_nxt,
  output logic [ACC_W-1:0] filt_nxt,
  output logic carry,
  output logic adds
);

  if (ACC_W < 2) begin : g_bad_width
    $error("aaf_filter_calc: accumulator too narrow");
  end

  function automatic logic [ACC_W-1:0] shr(input logic [ACC_W-1:0] v,
                                           input logic [2:0] s);
    shr = v >> s;
  endfunction

  logic [ACC_W:0] sum;
  logic [ACC_W:0] lsum;
  logic [2:0] lpf_shift;

  always_comb begin
    // A zero shift would reduce the low-pass recursion to a copy of the sample, so it acts as one.
    lpf_shift = (shift == 3'd0) ? 3'd1 : shift;
    sum = {1'b0, base} + {1'b0, sample};
    lsum = sum - {1'b0, shr(base, lpf_shift)};
    acc_nxt = base;
    filt_nxt = shr(base, shift);
    carry = 1'b0;
    adds = 1'b0;
    unique case (mode)
      `AAF_MD_ACC, `AAF_MD_AVG, `AAF_MD_BAVG: begin
        acc_nxt = sum[ACC_W-1:0];
        carry = sum[ACC_W];
        filt_nxt = shr(sum[ACC_W-1:0], shift);
        adds = 1'b1;
      end
      `AAF_MD_LPF: begin
        acc_nxt = lsum[ACC_W-1:0];
        carry = lsum[ACC_W];
        filt_nxt = shr(lsum[ACC_W-1:0], lpf_shift);
        adds = 1'b1;
      end
      default: begin
        adds = 1'b0;
      end
    endcase
  end

endmodule

/* aaf_top.sv */
// Accumulate, average and low-pass unit behind the converter, on APB.
// Function
// - Sixteen-bit accumulator, readable as separate low and high bytes.
// - In accumulate, average and low-pass modes, each trigger's conversion result is added into the accumulator.
// - A carry out of the accumulator sets the overflow flag.
// - Every sample added increments the sample counter by one.
// - Clearing also zeroes the overflow flag and the sample counter.
// - Clear command bit drops by itself when clearing completes.
// - On the internal RC clock, clearing takes five RC cycles.
// - Average modes shift the sum right by the shift count.
// - Low-pass mode uses shift counts one to seven inside its recursion.
// - Basic mode accumulates nothing but still compares thresholds.
// - Basic mode keeps conversion start and stage reporting working.
// - Accumulate mode adds every conversion result into the accumulator.
// - Accumulate mode loads the shifted accumulator into the filtered result.
// - Filtered result is always right justified.
// - Status bit 7 shows accumulator or error overflow.
// - Status bit 6 shows error above the upper threshold.
// - Status bit 5 shows error below the lower threshold.
// - Status bit 4 is set when results, thresholds or overflow change.
// - Status bits 2:0 show the converter stage; code 100 never shows.
`timescale 1ns/1ps
`include "aaf_regs.svh"
module aaf_top #(
  parameter int RESULT_W = 12,
  parameter int CNT_W = 8,
  parameter int RC_DIV = 50
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rstn,
  // Register bus.
  input wire aaf_pkg::aaf_apb_req_s apb_req,
  output aaf_pkg::aaf_apb_rsp_s apb_rsp,
  // Converter core.
  input wire aaf_pkg::aaf_core_s core,
  input wire logic ext_trigger,
  output logic conv_start
);
  import aaf_pkg::*;

  localparam int ACC_W = 16;
  localparam logic [15:0] RES_MASK = 16'((32'h1 << RESULT_W) - 1);
  localparam logic [15:0] RC_LAST = 16'(RC_DIV - 1);

  if (RESULT_W < 1 || RESULT_W > ACC_W || CNT_W < 1 || CNT_W > 16 ||
      RC_DIV < 1 || RC_DIV > 65535) begin : g_bad_param
    $error("aaf_top: unsupported parameter value");
  end

  function automatic logic is_reg(input logic [`AAF_IDX_W-1:0] idx,
                                  input logic [`AAF_IDX_W-1:0] code);
    is_reg = (idx == code);
  endfunction

  // Bus state.
  logic [31:0] prdata_r;
  logic pready_r;
  logic pslverr_r;
  logic [31:0] rd_data;
  logic mapped;
  // Settings.
  logic [2:0] mode_r;
  logic [2:0] shift_r;
  logic rc_sel_r;
  logic [CNT_W-1:0] repeat_r;
  logic [15:0] uth_r;
  logic [15:0] lth_r;
  logic [15:0] setp_r;
  // Computation state.
  logic [ACC_W-1:0] acc_r;
  logic [ACC_W-1:0] filt_r;
  logic [15:0] last_res_r;
  logic [CNT_W-1:0] cnt_r;
  logic ov_r;
  logic upper_r;
  logic lower_r;
  logic computation_status_bit_r;
  logic [2:0] stage_r;
  logic conv_start_r;
  // Clear sequencing.
  aaf_clr_e clr_state_r;
  logic [2:0] clr_ticks_r;
  logic [15:0] rc_div_r;
  logic rc_tick_r;

  logic [`AAF_IDX_W-1:0] idx;
  logic setup_ph;
  logic wr;
  logic wr_ctrl;
  logic wr_stat;
  logic clr_done;
  logic smp_add;
  logic [ACC_W-1:0] sample;
  logic [ACC_W-1:0] base;
  logic [ACC_W-1:0] acc_nxt;
  logic [ACC_W-1:0] filt_nxt;
  logic carry;
  logic adds;
  logic [15:0] err_val;
  logic signed [17:0] err;
  logic err_ovf;
  logic computation_status_bit_set;

  assign idx = apb_req.paddr[11:2];
  assign setup_ph = apb_req.psel && !apb_req.penable;
  assign wr = apb_req.psel && apb_req.penable && pready_r &&
              apb_req.pwrite && !pslverr_r;
  assign wr_ctrl = wr && is_reg(idx, `AAF_IDX_CTRL);
  assign wr_stat = wr && is_reg(idx, `AAF_IDX_STAT);

  assign apb_rsp.prdata = prdata_r;
  assign apb_rsp.pready = pready_r;
  assign apb_rsp.pslverr = pslverr_r;
  assign conv_start = conv_start_r;

  always_comb begin
    rd_data = 32'h0000_0000;
    mapped = (apb_req.paddr[1:0] == 2'b00);
    unique case (idx)
      `AAF_IDX_CTRL: begin
        rd_data[`AAF_CTRL_MODE_LSB +: 3] = mode_r;
        rd_data[`AAF_CTRL_SHIFT_LSB +: 3] = shift_r;
        rd_data[`AAF_CTRL_CLEAR_BIT] = (clr_state_r == CLR_WAIT);
        rd_data[`AAF_CTRL_RCSEL_BIT] = rc_sel_r;
      end
      `AAF_IDX_RPT: rd_data[CNT_W-1:0] = repeat_r;
      `AAF_IDX_CNT: rd_data[CNT_W-1:0] = cnt_r;
      `AAF_IDX_ACCL: rd_data[7:0] = acc_r[7:0];
      `AAF_IDX_ACCH: rd_data[7:0] = acc_r[15:8];
      `AAF_IDX_STAT: rd_data[7:0] = {ov_r, upper_r, lower_r, computation_status_bit_r,
                                     1'b0, stage_r};
      `AAF_IDX_FLT: rd_data[15:0] = filt_r;
      `AAF_IDX_UTH: rd_data[15:0] = uth_r;
      `AAF_IDX_LTH: rd_data[15:0] = lth_r;
      `AAF_IDX_SETP: rd_data[15:0] = setp_r;
      default: mapped = 1'b0;
    endcase
  end

  // Answers are prepared in the setup cycle so that the bus outputs are
  // flip-flops; every access therefore has exactly one access cycle.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      prdata_r <= 32'h0000_0000;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end else if (setup_ph) begin
      prdata_r <= apb_req.pwrite ? 32'h0000_0000 : rd_data;
      pready_r <= 1'b1;
      pslverr_r <= !mapped;
    end else begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mode_r <= `AAF_MD_BASIC;
      shift_r <= 3'd0;
      rc_sel_r <= 1'b0;
      repeat_r <= '0;
      uth_r <= `AAF_THR_RESET;
      lth_r <= `AAF_THR_RESET;
      setp_r <= 16'h0000;
    end else if (wr) begin
      if (wr_ctrl) begin
        mode_r <= apb_req.pwdata[`AAF_CTRL_MODE_LSB +: 3];
        shift_r <= apb_req.pwdata[`AAF_CTRL_SHIFT_LSB +: 3];
        rc_sel_r <= apb_req.pwdata[`AAF_CTRL_RCSEL_BIT];
      end
      if (is_reg(idx, `AAF_IDX_RPT)) repeat_r <= apb_req.pwdata[CNT_W-1:0];
      if (is_reg(idx, `AAF_IDX_UTH)) uth_r <= apb_req.pwdata[15:0];
      if (is_reg(idx, `AAF_IDX_LTH)) lth_r <= apb_req.pwdata[15:0];
      if (is_reg(idx, `AAF_IDX_SETP)) setp_r <= apb_req.pwdata[15:0];
    end
  end

  // Software go bit and the external trigger both start a conversion,
  // in every mode including basic.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      conv_start_r <= 1'b0;
    end else begin
      conv_start_r <= ext_trigger ||
                      (wr_ctrl && apb_req.pwdata[`AAF_CTRL_GO_BIT]);
    end
  end

  // Divider that stands in for the internal RC clock as an enable pulse.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rc_div_r <= 16'h0000;
      rc_tick_r <= 1'b0;
    end else begin
      rc_tick_r <= (rc_div_r == RC_LAST);
      rc_div_r <= (rc_div_r == RC_LAST) ? 16'h0000 : rc_div_r + 16'h0001;
    end
  end

  // A clear on the RC clock ends on the fifth RC tick after the request.
  assign clr_done = (clr_state_r == CLR_WAIT) &&
                    (!rc_sel_r || (rc_tick_r &&
                     clr_ticks_r == `AAF_CLR_RC_CYCLES - 3'd1));

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      clr_state_r <= CLR_IDLE;
      clr_ticks_r <= 3'd0;
    end else begin
      unique case (clr_state_r)
        CLR_IDLE: begin
          clr_ticks_r <= 3'd0;
          if (wr_ctrl && apb_req.pwdata[`AAF_CTRL_CLEAR_BIT]) begin
            clr_state_r <= CLR_WAIT;
          end
        end
        CLR_WAIT: begin
          if (clr_done) begin
            clr_state_r <= CLR_IDLE;
          end else if (rc_tick_r) begin
            clr_ticks_r <= clr_ticks_r + 3'd1;
          end
        end
      endcase
    end
  end

  // A sample that lands on the clearing cycle starts the new sum.
  assign sample = core.result & RES_MASK;
  assign base = clr_done ? '0 : acc_r;
  assign smp_add = core.valid && adds;

  aaf_filter_calc #(
    .ACC_W(ACC_W)
  ) u_calc (
    .mode(mode_r),
    .shift(shift_r),
    .base(base),
    .sample(sample),
    .acc_nxt(acc_nxt),
    .filt_nxt(filt_nxt),
    .carry(carry),
    .adds(adds)
  );

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      acc_r <= '0;
      filt_r <= '0;
      last_res_r <= 16'h0000;
    end else begin
      if (core.valid) last_res_r <= sample;
      if (smp_add) begin
        acc_r <= acc_nxt;
        filt_r <= filt_nxt;
      end else if (clr_done) begin
        acc_r <= '0;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt_r <= '0;
    end else if (clr_done) begin
      cnt_r <= smp_add ? CNT_W'(1) : '0;
    end else if (smp_add) begin
      cnt_r <= cnt_r + CNT_W'(1);
    end
  end

  // Basic mode compares the raw result; other modes the filtered one.
  assign err_val = (mode_r == `AAF_MD_BASIC) ? last_res_r : filt_r;
  assign err = $signed({2'b00, err_val}) - $signed({2'b00, setp_r});
  assign err_ovf = (err > 18'sd32767) || (err < -18'sd32768);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      upper_r <= 1'b0;
      lower_r <= 1'b0;
    end else begin
      upper_r <= err > $signed({{2{uth_r[15]}}, uth_r});
      lower_r <= err < $signed({{2{lth_r[15]}}, lth_r});
    end
  end

  // Overflow set wins over a clear finishing in the same cycle.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ov_r <= 1'b0;
    end else if ((smp_add && carry) || err_ovf) begin
      ov_r <= 1'b1;
    end else if (clr_done) begin
      ov_r <= 1'b0;
    end
  end

  assign computation_status_bit_set = smp_add || clr_done || (err_ovf && !ov_r) ||
                    (wr && (is_reg(idx, `AAF_IDX_UTH) ||
                            is_reg(idx, `AAF_IDX_LTH)));

  // Write one to the computation bit to clear it; a new update wins.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      computation_status_bit_r <= 1'b0;
    end else if (computation_status_bit_set) begin
      computation_status_bit_r <= 1'b1;
    end else if (wr_stat && apb_req.pwdata[`AAF_STAT_COMPUTATION_STATUS_BIT_BIT]) begin
      computation_status_bit_r <= 1'b0;
    end
  end

  // The unused stage code is shown as idle.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      stage_r <= `AAF_STAGE_IDLE;
    end else begin
      stage_r <= (core.stage == `AAF_STAGE_UNUSED) ?
                 `AAF_STAGE_IDLE : core.stage;
    end
  end

  // Ticks seen since the clear began, kept apart from the sequencer.
  logic [2:0] hlp_rc_seen;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      hlp_rc_seen <= 3'd0;
    end else if (clr_state_r != CLR_WAIT) begin
      hlp_rc_seen <= 3'd0;
    end else if (rc_tick_r && hlp_rc_seen != 3'd7) begin
      hlp_rc_seen <= hlp_rc_seen + 3'd1;
    end
  end

  property p_count_inc;
    @(posedge clk) disable iff (!rstn)
    smp_add && !clr_done |=> cnt_r == $past(cnt_r) + 1'b1;
  endproperty
  a_count_inc: assert property (p_count_inc)
    else $error("sample counter did not step by one");

  property p_clear_zero;
    @(posedge clk) disable iff (!rstn)
    clr_done && !core.valid |=> acc_r == '0 && cnt_r == '0 &&
      (!ov_r || $past(err_ovf));
  endproperty
  a_clear_zero: assert property (p_clear_zero)
    else $error("clear left accumulator, counter or overflow set");

  property p_clear_drop;
    @(posedge clk) disable iff (!rstn)
    clr_done |=> clr_state_r == CLR_IDLE;
  endproperty
  a_clear_drop: assert property (p_clear_drop)
    else $error("clear command stayed set after completion");

  property p_rc_five;
    @(posedge clk) disable iff (!rstn)
    clr_state_r == CLR_WAIT && rc_sel_r |->
      hlp_rc_seen <= 3'd4 && (!clr_done || (rc_tick_r && hlp_rc_seen == 3'd4));
  endproperty
  a_rc_five: assert property (p_rc_five)
    else $error("RC clear did not take five RC cycles");

  property p_basic_hold;
    @(posedge clk) disable iff (!rstn)
    mode_r == `AAF_MD_BASIC && !clr_done |=> $stable(acc_r);
  endproperty
  a_basic_hold: assert property (p_basic_hold)
    else $error("accumulator changed in basic mode");

  property p_ov_carry;
    @(posedge clk) disable iff (!rstn)
    smp_add && carry |=> ov_r;
  endproperty
  a_ov_carry: assert property (p_ov_carry)
    else $error("accumulator carry did not set overflow");

  property p_upper;
    @(posedge clk) disable iff (!rstn)
    $stable(err) && $stable(uth_r) |=>
      upper_r == ($past(err) > $signed({{2{$past(uth_r[15])}}, $past(uth_r)}));
  endproperty
  a_upper: assert property (p_upper)
    else $error("upper threshold flag wrong");

  property p_lower;
    @(posedge clk) disable iff (!rstn)
    ##1 lower_r |-> $past(err) < $signed({{2{$past(lth_r[15])}},
                                         $past(lth_r)});
  endproperty
  a_lower: assert property (p_lower)
    else $error("lower threshold flag set without cause");

  property p_computation_status_bit_set;
    @(posedge clk) disable iff (!rstn)
    smp_add |=> computation_status_bit_r;
  endproperty
  a_computation_status_bit_set: assert property (p_computation_status_bit_set)
    else $error("computation bit not set after an update");

  property p_computation_status_bit_hold;
    @(posedge clk) disable iff (!rstn)
    computation_status_bit_r && !(wr_stat && apb_req.pwdata[`AAF_STAT_COMPUTATION_STATUS_BIT_BIT]) |=> computation_status_bit_r;
  endproperty
  a_computation_status_bit_hold: assert property (p_computation_status_bit_hold)
    else $error("computation bit dropped without a software clear");

  property p_stage;
    @(posedge clk) disable iff (!rstn)
    stage_r != `AAF_STAGE_UNUSED;
  endproperty
  a_stage: assert property (p_stage)
    else $error("unused stage code shown");

  property p_filt_acc;
    @(posedge clk) disable iff (!rstn)
    smp_add && mode_r == `AAF_MD_ACC |=>
      filt_r == ($past(acc_nxt) >> $past(shift_r));
  endproperty
  a_filt_acc: assert property (p_filt_acc)
    else $error("filtered result is not the shifted accumulator");

endmodule

/* aaf_core_model.sv */
// Behavioural converter core that answers conversion starts with results.
`timescale 1ns/1ps
module aaf_core_model (
  // Clock and reset.
  input wire logic clk,
  input wire logic rstn,
  // Start from the unit, sample value and stage length from the bench.
  input wire logic conv_start,
  input wire logic [15:0] smp,
  input wire logic [3:0] hold,
  // Conversion output.
  output aaf_pkg::aaf_core_s core
);
  import aaf_pkg::*;
  logic [1:0] st_r;
  logic [3:0] cnt_r;
  logic valid_r;
  logic [15:0] res_r;
  assign core = '{valid: valid_r, result: res_r, stage: {1'b0, st_r}};
  // Stages 1 to 3 are precharge, acquisition and conversion.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_r <= 2'd0;
      cnt_r <= 4'd0;
      valid_r <= 1'b0;
      res_r <= 16'h0000;
    end else begin
      valid_r <= 1'b0;
      if (st_r == 2'd0) begin
        // While idle the data lines invert on every cycle and never hold a value.
        res_r <= ~res_r;
        if (conv_start) begin
          st_r <= 2'd1;
          cnt_r <= hold;
        end
      end else if (cnt_r != 4'd0) begin
        cnt_r <= cnt_r - 4'd1;
      end else if (st_r == 2'd3) begin
        valid_r <= 1'b1;
        res_r <= smp;
        st_r <= 2'd0;
      end else begin
        st_r <= st_r + 2'd1;
        cnt_r <= hold;
      end
    end
  end
endmodule

/* tb_top.sv */
// Self-checking bench for the accumulate and filter unit.
`timescale 1ns/1ps
`include "aaf_regs.svh"
`define CHK(g, e) chk(32'(g), 32'(e))
module tb_top;
  import aaf_pkg::*;
  localparam int RCD = 2;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  aaf_apb_req_s req = '0;
  aaf_apb_rsp_s rsp;
  aaf_core_s core;
  logic ext_trigger = 1'b0;
  logic conv_start;
  logic [15:0] smp = 16'h0000;
  logic [3:0] hold = 4'h0;
  int seed = 1387;
  int mismatches = 0;
  int cmp_count = 0;
  int cyc = 0;
  int starts = 0;
  int n;
  int e;
  logic [31:0] rd;
  logic err;
  logic [15:0] acc = 16'h0000;
  logic [15:0] filt;
  logic [15:0] v;
  logic [7:0] cnt = 8'h00;
  logic ov = 1'b0;
  logic [2:0] md = 3'b000;
  logic [2:0] sh = 3'b000;
  logic [16:0] t;
  logic [15:0] corner [5] = '{16'h0200, 16'h0000, 16'h0120, 16'h0150,
                              16'h00B0};

  always #10 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;
  always @(posedge clk) if (conv_start === 1'b1) starts <= starts + 1;

  aaf_top #(.RC_DIV(RCD)) aaf_top_inst (.clk(clk), .rstn(rstn),
    .apb_req(req), .apb_rsp(rsp), .core(core), .ext_trigger(ext_trigger),
    .conv_start(conv_start));
  aaf_core_model aaf_core_model_inst (.clk(clk), .rstn(rstn),
    .conv_start(conv_start), .smp(smp), .hold(hold), .core(core));

  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    cmp_count++;
    if (g !== x) begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, g, x);
    end
  endtask

  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic apb(input logic w, input logic [9:0] idx,
                     input logic [31:0] wd);
    int k;
    @(posedge clk);
    req.psel <= 1'b1;
    req.penable <= 1'b0;
    req.pwrite <= w;
    req.paddr <= {idx, 2'b00};
    req.pwdata <= wd;
    @(posedge clk);
    req.penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (rsp.pready !== 1'b1 && k < 16);
    if (k == 16) mismatches++;
    rd = rsp.prdata;
    err = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask

  task automatic rchk(input logic [9:0] idx, input logic [31:0] x);
    apb(1'b0, idx, 32'h0000_0000);
    `CHK(rd, x);
  endtask

  function automatic logic [16:0] nxt(input logic [2:0] m, input logic [2:0] s,
                                      input logic [15:0] a, x);
    if (m == `AAF_MD_LPF) return {1'b0, a + x - (a >> s)};
    return {1'b0, a} + {1'b0, x};
  endfunction

  // Keeps sums below the error overflow point for the chosen shift.
  function automatic logic [15:0] lim(input logic [2:0] s);
    return (s >= 3'd4) ? (16'h8000 >> s) - 16'h0001 : 16'h0FFF;
  endfunction

  task automatic conv(input logic [15:0] x, input logic ext);
    int k;
    @(posedge clk);
    smp <= x;
    hold <= 4'($random(seed) & 3);
    ext_trigger <= ext;
    if (ext) begin
      @(posedge clk);
      ext_trigger <= 1'b0;
    end else begin
      apb(1'b1, `AAF_IDX_CTRL, {21'b0, 1'b1, 3'b000, sh, 1'b0, md});
    end
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (core.valid !== 1'b1 && k < 100);
    if (k == 100) mismatches++;
    if (md != `AAF_MD_BASIC) begin
      t = nxt(md, sh, acc, x);
      acc = t[15:0];
      ov = ov | t[16];
      filt = acc >> sh;
      cnt = cnt + 8'd1;
    end
    repeat (3) @(posedge clk);
  endtask

  task automatic clr(input logic rc);
    apb(1'b1, `AAF_IDX_CTRL, {22'b0, rc, 1'b1, 1'b0, sh, 1'b0, md});
    acc = 16'h0000;
    cnt = 8'h00;
    ov = 1'b0;
  endtask

  initial begin
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    for (int i = `AAF_IDX_CTRL; i <= `AAF_IDX_SETP; i++) begin
      rchk(10'(i), 32'h0000_0000);
    end
    rchk(10'h120, 32'h0000_0000);
    `CHK(err, 1'b1);
    apb(1'b1, `AAF_IDX_CNT, 32'h0000_0055);
    rchk(`AAF_IDX_CNT, 32'h0000_0000);
    apb(1'b1, `AAF_IDX_RPT, 32'h0000_0007);
    rchk(`AAF_IDX_RPT, 32'h0000_0007);
    for (int m = 0; m < 5; m++) begin
      md = 3'(m);
      sh = 3'($random(seed));
      if (m == 4 && sh == 3'd0) sh = 3'd7;
      clr(1'b0);
      rchk(`AAF_IDX_CTRL, {25'b0, sh, 1'b0, md});
      rchk(`AAF_IDX_CNT, 32'h0000_0000);
      rchk(`AAF_IDX_ACCL, 32'h0000_0000);
      for (int k = 0; k < 7; k++) conv(16'($random(seed)) & lim(sh), k[0]);
      rchk(`AAF_IDX_CNT, cnt);
      rchk(`AAF_IDX_ACCL, acc[7:0]);
      rchk(`AAF_IDX_ACCH, acc[15:8]);
      if (m != 0) rchk(`AAF_IDX_FLT, filt);
      apb(1'b0, `AAF_IDX_STAT, 32'h0000_0000);
      `CHK(rd[7], ov);
    end
    md = `AAF_MD_ACC;
    sh = 3'd0;
    clr(1'b0);
    repeat (17) conv(16'h0FFF, 1'b0);
    apb(1'b0, `AAF_IDX_STAT, 32'h0000_0000);
    `CHK(rd[7], ov);
    rchk(`AAF_IDX_ACCL, acc[7:0]);
    clr(1'b0);
    apb(1'b0, `AAF_IDX_STAT, 32'h0000_0000);
    `CHK(rd[7], 1'b0);
    apb(1'b1, `AAF_IDX_STAT, 32'h0000_0010);
    apb(1'b0, `AAF_IDX_STAT, 32'h0000_0000);
    `CHK(rd[4], 1'b0);
    conv(16'h0010, 1'b1);
    apb(1'b0, `AAF_IDX_STAT, 32'h0000_0000);
    `CHK(rd[4], 1'b1);
    clr(1'b1);
    n = cyc;
    rchk(`AAF_IDX_CTRL, {22'b0, 1'b1, 1'b1, 1'b0, sh, 1'b0, md});
    do apb(1'b0, `AAF_IDX_CTRL, 32'h0000_0000);
    while (rd[8] !== 1'b0 && cyc - n < 100);
    `CHK(cyc - n > 4 * RCD, 1'b1);
    `CHK(cyc - n <= 6 * RCD + 8, 1'b1);
    rchk(`AAF_IDX_CNT, 32'h0000_0000);
    md = `AAF_MD_BASIC;
    apb(1'b1, `AAF_IDX_CTRL, 32'h0000_0000);
    @(posedge clk);
    hold <= 4'd8;
    ext_trigger <= 1'b1;
    @(posedge clk);
    ext_trigger <= 1'b0;
    repeat (3) @(posedge clk);
    apb(1'b0, `AAF_IDX_STAT, 32'h0000_0000);
    `CHK(rd[2:0] inside {3'b001, 3'b010, 3'b011}, 1'b1);
    repeat (40) @(posedge clk);
    apb(1'b0, `AAF_IDX_STAT, 32'h0000_0000);
    `CHK(rd[2:0], 3'b000);
    apb(1'b1, `AAF_IDX_SETP, 32'h0000_0100);
    apb(1'b1, `AAF_IDX_UTH, 32'h0000_0050);
    apb(1'b1, `AAF_IDX_LTH, 32'h0000_FFB0);
    rchk(`AAF_IDX_LTH, 32'h0000_FFB0);
    for (int i = 0; i < 10; i++) begin
      v = (i < 5) ? corner[i] : 16'($random(seed)) & 16'h03FF;
      conv(v, i[0]);
      e = int'(v) - 256;
      apb(1'b0, `AAF_IDX_STAT, 32'h0000_0000);
      `CHK(rd[6:5], {e > 80, e < -80});
    end
    rchk(`AAF_IDX_CNT, 32'h0000_0000);
    `CHK(starts, 64);
    report_and_stop;
  end

  initial begin
    #1000000;
    mismatches++;
    report_and_stop;
  end
endmodule
